// >>> design/config_word_loader.sv
// Configuration loader: fetches flash words on reset, holds write-once bytes.
// Assumes flash answers a read with a one-cycle valid; table access synchronous.
`timescale 1ns/10ps
`default_nettype none
`include "cfgload_cfg.svh"
module config_word_loader (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // Variant and word count
  input wire logic NONVOLATILE,
  input wire logic [2:0] NUM_WORDS,
  input wire logic SOFT_RESET,
  input wire logic NV_DISRUPT,
  // Flash read port
  output logic FLASH_RD,
  output logic [23:0] FLASH_ADDR,
  input wire logic FLASH_VALID,
  input wire logic [23:0] FLASH_DATA,
  // Table access
  input wire logic TBL_WR,
  input wire logic TBL_RD,
  input wire logic [23:0] TBL_ADDR,
  input wire logic [7:0] TBL_WDATA,
  output logic [23:0] TBL_RDATA,
  output logic TBL_RVALID,
  // Resets and decoded options
  output logic CORE_RESET,
  output logic CONFIG_MISMATCH_RESET,
  output logic [2:0] BOOT_SEGMENT_SECURITY,
  output logic [1:0] CLOCK_SWITCH_MONITOR_SEL,
  output logic [2:0] INITIAL_OSCILLATOR_SEL,
  output logic [1:0] PRIMARY_OSCILLATOR_MODE,
  output logic [3:0] WATCHDOG_POSTSCALER,
  output logic PIN_MAPPING_LOCK,
  output logic [7:0] PROTECT_PAGE_FIELD,
  output logic SEGMENT_END_SELECT,
  output logic SEGMENT_PROTECT_ENABLE,
  output logic LAST_PAGE_PROTECT
);
  cfgload_pkg::load_state_e state_r;
  logic [1:0] word_idx_r;
  logic [2:0] nwords;
  logic [7:0] lo_b;
  logic [7:0] hi_b;
  logic [7:0] vals [8];
  logic [7:0] mm;
  logic any_mm;
  logic loading;
  logic tbl_hit;
  logic [2:0] tbl_idx;
  cfg_field_if fi [8] ();
  // ---------------------------------------------------------------
  // Word count and scatter
  // ---------------------------------------------------------------
  // Counts outside two to four are clamped
  assign nwords = (NUM_WORDS < 3'd2) ? 3'd2 : (NUM_WORDS > 3'd4) ? 3'd4 : NUM_WORDS; // RQ5
  assign loading = (state_r != cfgload_pkg::ST_RUN);
  cfg_word_scatter u_scatter (
    .word(FLASH_DATA[15:0]),
    .lo_byte(lo_b),
    .hi_byte(hi_b)
  );
  // Table decode: low byte of each register address only
  assign tbl_hit = (TBL_ADDR >= `CFG_SPACE_LO)
    && (TBL_ADDR[23:5] == 19'(`CFG_BASE_ADDR >> 5)); // RQ2 RQ13
  always_comb begin
    tbl_idx = 3'd0;
    unique case (TBL_ADDR)
      `CFG_OFS_BOOT: tbl_idx = 3'd0; // RQ1
      `CFG_OFS_GSEG: tbl_idx = 3'd1;
      `CFG_OFS_OSEL: tbl_idx = 3'd2;
      `CFG_OFS_OSC: tbl_idx = 3'd3;
      `CFG_OFS_WDT: tbl_idx = 3'd4;
      `CFG_OFS_RST: tbl_idx = 3'd5;
      `CFG_OFS_DBG: tbl_idx = 3'd6;
      `CFG_OFS_DSLP: tbl_idx = 3'd7;
      default: tbl_idx = 3'd0;
    endcase
  end
  wire tbl_valid_addr = tbl_hit && (TBL_ADDR[0] == 1'b0) && (TBL_ADDR <= `CFG_OFS_DSLP)
    && (TBL_ADDR != 24'hF80002); // RQ14
  // ---------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_reg
      logic ld;
      // Word k fills bytes 2k and 2k+1
      assign ld = loading && FLASH_VALID && (state_r == cfgload_pkg::ST_WAIT)
        && (word_idx_r == 2'(g / 2));
      assign fi[g].wr_en = ld || (!loading && TBL_WR && tbl_valid_addr && tbl_idx == 3'(g));
      assign fi[g].wr_data = ld ? ((g % 2 == 0) ? lo_b : hi_b) : TBL_WDATA;
      assign vals[g] = fi[g].value;
      assign mm[g] = fi[g].mismatch;
      cfg_once_reg u_reg (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .nonvolatile(NONVOLATILE),
        .clear_lock(state_r == cfgload_pkg::ST_RESET),
        .fi(fi[g])
      );
    end
  endgenerate
  assign any_mm = |mm;
  // ---------------------------------------------------------------
  // Load sequence
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= cfgload_pkg::ST_RESET;
      word_idx_r <= 2'd0;
    end else if (CE) begin
      unique case (state_r)
        cfgload_pkg::ST_RESET: begin
          word_idx_r <= 2'd0;
          // Nonvolatile contents are already live
          state_r <= NONVOLATILE ? cfgload_pkg::ST_RUN : cfgload_pkg::ST_REQ; // RQ3
        end
        cfgload_pkg::ST_REQ: state_r <= cfgload_pkg::ST_WAIT;
        cfgload_pkg::ST_WAIT: if (FLASH_VALID) begin
          state_r <= cfgload_pkg::ST_NEXT;
        end
        cfgload_pkg::ST_NEXT: begin
          if ({1'b0, word_idx_r} + 3'd1 >= nwords) begin
            state_r <= cfgload_pkg::ST_RUN;
          end else begin
            word_idx_r <= word_idx_r + 2'd1;
            state_r <= cfgload_pkg::ST_REQ;
          end
        end
        cfgload_pkg::ST_RUN: begin
          // Mismatch, soft reset or nonvolatile disturbance return to ST_RESET; only the volatile variant then reloads
          if (SOFT_RESET || any_mm || (NONVOLATILE && NV_DISRUPT)) begin // RQ9 RQ12 RQ16
            state_r <= cfgload_pkg::ST_RESET;
          end
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Flash port
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FLASH_RD <= 1'b0;
      FLASH_ADDR <= 24'h000000;
    end else if (CE) begin
      FLASH_RD <= (state_r == cfgload_pkg::ST_REQ);
      if (state_r == cfgload_pkg::ST_REQ) begin
        // Fourth word two below third, so a uniform step applies
        FLASH_ADDR <= `CFG_LAST_PM_WORD - (24'(word_idx_r) * `CFG_WORD_STEP); // RQ6
      end
    end
  end
  // ---------------------------------------------------------------
  // Reset outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CORE_RESET <= 1'b1;
      CONFIG_MISMATCH_RESET <= 1'b0;
    end else if (CE) begin
      CORE_RESET <= (state_r != cfgload_pkg::ST_RUN) || SOFT_RESET; // RQ21
      CONFIG_MISMATCH_RESET <= (state_r == cfgload_pkg::ST_RUN)
        && (any_mm || (NONVOLATILE && NV_DISRUPT)); // RQ9 RQ16
    end
  end
  // ---------------------------------------------------------------
  // Table read
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TBL_RDATA <= 24'h000000;
      TBL_RVALID <= 1'b0;
    end else if (CE) begin
      TBL_RVALID <= TBL_RD;
      // Upper bytes read zero
      TBL_RDATA <= (TBL_RD && tbl_valid_addr) ? {16'h0000, vals[tbl_idx]} : 24'h000000; // RQ14
    end
  end
  // ---------------------------------------------------------------
  // Decoded options
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BOOT_SEGMENT_SECURITY <= 3'h7;
      CLOCK_SWITCH_MONITOR_SEL <= 2'h3;
      INITIAL_OSCILLATOR_SEL <= 3'h7;
      PRIMARY_OSCILLATOR_MODE <= 2'h3;
      WATCHDOG_POSTSCALER <= 4'hF;
      PIN_MAPPING_LOCK <= 1'b1;
      PROTECT_PAGE_FIELD <= 8'hFF;
      SEGMENT_END_SELECT <= 1'b1;
      SEGMENT_PROTECT_ENABLE <= 1'b0;
      LAST_PAGE_PROTECT <= 1'b0;
    end else if (CE) begin
      BOOT_SEGMENT_SECURITY <= vals[0][`FLD_BSS_LSB +: 3]; // RQ19
      PROTECT_PAGE_FIELD <= vals[1];
      SEGMENT_END_SELECT <= vals[6][`FLD_SEND_BIT]; // RQ17
      // Programmed (zero) disable bit means protection on
      SEGMENT_PROTECT_ENABLE <= !vals[6][`FLD_SPD_BIT]; // RQ18 RQ7
      LAST_PAGE_PROTECT <= !vals[6][`FLD_LPP_BIT]; // RQ18
      INITIAL_OSCILLATOR_SEL <= vals[2][`FLD_NOSC_LSB +: 3]; // RQ19
      CLOCK_SWITCH_MONITOR_SEL <= vals[3][`FLD_CKSM_LSB +: 2];
      PRIMARY_OSCILLATOR_MODE <= vals[3][`FLD_POSC_LSB +: 2];
      PIN_MAPPING_LOCK <= vals[3][`FLD_LOCK_BIT]; // RQ20
      WATCHDOG_POSTSCALER <= vals[4][`FLD_WDPS_LSB +: 4];
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_core_held: assert property (@(posedge CLK) disable iff (RST) // RQ21
    (CE && state_r != cfgload_pkg::ST_RUN) |=> CORE_RESET)
    else $error("core released during load");
  a_mismatch_fires: assert property (@(posedge CLK) disable iff (RST) // RQ9
    (CE && state_r == cfgload_pkg::ST_RUN && any_mm) |=> CONFIG_MISMATCH_RESET)
    else $error("mismatch reset missing");
  a_word_addr: assert property (@(posedge CLK) disable iff (RST) // RQ6
    (CE && state_r == cfgload_pkg::ST_REQ && word_idx_r == 2'd0)
    |=> FLASH_ADDR == `CFG_LAST_PM_WORD)
    else $error("first word address wrong");
  a_load_reloads: assert property (@(posedge CLK) disable iff (RST) // RQ12
    (CE && state_r == cfgload_pkg::ST_RUN && SOFT_RESET)
    |=> state_r == cfgload_pkg::ST_RESET)
    else $error("soft reset did not reload");
  a_nv_immediate: assert property (@(posedge CLK) disable iff (RST) // RQ15
    (CE && NONVOLATILE && fi[0].wr_en) |=> vals[0] == $past(fi[0].wr_data))
    else $error("nonvolatile write not immediate");
  a_read_upper_zero: assert property (@(posedge CLK) disable iff (RST) // RQ14
    TBL_RVALID |-> TBL_RDATA[23:8] == 16'h0000)
    else $error("table read upper bits set");
  a_nv_disrupt: assert property (@(posedge CLK) disable iff (RST) // RQ16
    (CE && NONVOLATILE && NV_DISRUPT && state_r == cfgload_pkg::ST_RUN)
    |=> CONFIG_MISMATCH_RESET)
    else $error("disruption ignored");
  a_first_load: assert property (@(posedge CLK) disable iff (RST) // RQ3
    (CE && !NONVOLATILE && state_r == cfgload_pkg::ST_RESET)
    |=> state_r == cfgload_pkg::ST_REQ)
    else $error("load not started");
  c_load_done: cover property (@(posedge CLK) disable iff (RST)
    state_r == cfgload_pkg::ST_NEXT ##1 state_r == cfgload_pkg::ST_RUN);
  c_mismatch: cover property (@(posedge CLK) disable iff (RST) CONFIG_MISMATCH_RESET);
  c_tbl_read: cover property (@(posedge CLK) disable iff (RST) TBL_RVALID && tbl_valid_addr);
  c_nv_write: cover property (@(posedge CLK) disable iff (RST)
    NONVOLATILE && TBL_WR && tbl_valid_addr && state_r == cfgload_pkg::ST_RUN);
  c_soft_reload: cover property (@(posedge CLK) disable iff (RST)
    CE && SOFT_RESET && state_r == cfgload_pkg::ST_RUN);
  // ---------------------------------------------------------------
  // Load sequence checks
  // ---------------------------------------------------------------
  // One read outstanding, so the strobe never stands two cycles
  a_flash_pulse: assert property (@(posedge CLK) disable iff (RST) // RQ3
    (CE && FLASH_RD) |=> !FLASH_RD)
    else $error("flash read strobe held");
  a_word0_scatter: assert property (@(posedge CLK) disable iff (RST) // RQ4
    (CE && state_r == cfgload_pkg::ST_WAIT && FLASH_VALID && word_idx_r == 2'h0)
    |=> vals[0] == $past(FLASH_DATA[7:0]) && vals[1] == $past(FLASH_DATA[15:8]))
    else $error("first word not scattered");
  a_word1_scatter: assert property (@(posedge CLK) disable iff (RST) // RQ4
    (CE && state_r == cfgload_pkg::ST_WAIT && FLASH_VALID && word_idx_r == 2'h1)
    |=> vals[2] == $past(FLASH_DATA[7:0]) && vals[3] == $past(FLASH_DATA[15:8]))
    else $error("second word not scattered");
  a_word4_addr: assert property (@(posedge CLK) disable iff (RST) // RQ6
    (CE && state_r == cfgload_pkg::ST_REQ && word_idx_r == 2'h3)
    |=> FLASH_ADDR == `CFG_LAST_PM_WORD - (`CFG_WORD_STEP * 24'h000002) - `CFG_WORD4_GAP)
    else $error("fourth word address wrong");
  a_min_words: assert property (@(posedge CLK) disable iff (RST) // RQ5
    (CE && state_r == cfgload_pkg::ST_NEXT && word_idx_r == 2'h0)
    |=> state_r == cfgload_pkg::ST_REQ)
    else $error("fewer than two words loaded");
  a_max_words: assert property (@(posedge CLK) disable iff (RST) // RQ5
    (CE && state_r == cfgload_pkg::ST_NEXT && word_idx_r == 2'h3)
    |=> state_r == cfgload_pkg::ST_RUN)
    else $error("more than four words loaded");
  a_load_quiet: assert property (@(posedge CLK) disable iff (RST) // RQ8
    (CE && state_r == cfgload_pkg::ST_REQ) |=> $stable(vals[7]))
    else $error("register changed between words");
  a_core_release: assert property (@(posedge CLK) disable iff (RST) // RQ21
    (CE && state_r == cfgload_pkg::ST_RUN && !SOFT_RESET) |=> !CORE_RESET)
    else $error("core held after load");
  // ---------------------------------------------------------------
  // Write-once and table checks
  // ---------------------------------------------------------------
  a_once_blocked: assert property (@(posedge CLK) disable iff (RST) // RQ8
    (CE && !NONVOLATILE && state_r == cfgload_pkg::ST_RUN)
    |=> $stable(vals[0]))
    else $error("locked byte overwritten");
  a_cmr_pulse: assert property (@(posedge CLK) disable iff (RST) // RQ9
    (CE && CONFIG_MISMATCH_RESET) |=> !CONFIG_MISMATCH_RESET)
    else $error("mismatch reset held");
  a_nv_no_load: assert property (@(posedge CLK) disable iff (RST) // RQ15
    (CE && NONVOLATILE && state_r == cfgload_pkg::ST_RESET) |=> state_r == cfgload_pkg::ST_RUN)
    else $error("nonvolatile variant loaded flash");
  a_nv_any_write: assert property (@(posedge CLK) disable iff (RST) // RQ15
    (CE && NONVOLATILE && state_r == cfgload_pkg::ST_RUN && TBL_WR && tbl_valid_addr)
    |=> vals[$past(tbl_idx)] == $past(TBL_WDATA))
    else $error("nonvolatile write lost");
  a_tbl_rvalid: assert property (@(posedge CLK) disable iff (RST) // RQ13
    (CE && TBL_RD) |=> TBL_RVALID)
    else $error("table read not answered");
  a_tbl_unmapped: assert property (@(posedge CLK) disable iff (RST) // RQ14
    (CE && TBL_RD && !tbl_valid_addr)
    |=> TBL_RDATA == 24'h000000)
    else $error("unmapped table read not zero");
endmodule
`default_nettype wire

// >>> inc/cfgload_cfg.svh
// Constants of the configuration word loader: offsets, fields, reset values.
// Assumes inclusion by bare name from design files; definitions only.
//
// Overview of operation
// RQ1 - Configuration registers map into program space from a fixed base F80000h.
// RQ2 - Addresses 800000h-FFFFFFh are configuration space, apart from user memory.
// RQ3 - Volatile variant reloads registers from flash words after every reset.
// RQ4 - Each flash word is a packed 16-bit image scattered into registers.
// RQ5 - Two to four flash configuration words are supported.
// RQ6 - Word one at last program word, others lower; fourth two below third.
// RQ7 - Bit reads zero when programmed, one when unprogrammed; value selects option.
// RQ8 - Volatile bits accept one write per reset; later writes blocked.
// RQ9 - Changing a loaded bit raises mismatch reset; rewriting flash word does not.
// RQ10 - Software keeps flash word upper byte all ones, a no-operation.
// RQ11 - Ones in the unimplemented upper byte change nothing.
// RQ12 - New flash word contents load after a software reset instruction.
// RQ13 - Nonvolatile bits sit in a separate block reached by table access only.
// RQ14 - Nonvolatile registers are 8 bits in the low byte of their address.
// RQ15 - Nonvolatile value takes effect immediately, no reset needed.
// RQ16 - Nonvolatile safety check still issues mismatch reset on disrupted contents.
// RQ17 - Segment-end select zero: page is start to top; one: page zero to page.
// RQ18 - Segment-protect disable governs segment and last page; last-page bit independent.
// RQ19 - Field widths: boot security 3, clock monitor 2, oscillator 3, mode 2, postscaler 4.
// RQ20 - Pin-mapping lock picks one run-time remap or unrestricted remaps.
// RQ21 - Core held in reset until the load sequence finishes.
`ifndef CFGLOAD_CFG_SVH
`define CFGLOAD_CFG_SVH
// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define CFG_BASE_ADDR 24'hF80000
`define CFG_SPACE_LO 24'h800000
`define CFG_OFS_BOOT 24'hF80000
`define CFG_OFS_GSEG 24'hF80004
`define CFG_OFS_OSEL 24'hF80006
`define CFG_OFS_OSC 24'hF80008
`define CFG_OFS_WDT 24'hF8000A
`define CFG_OFS_RST 24'hF8000C
`define CFG_OFS_DBG 24'hF8000E
`define CFG_OFS_DSLP 24'hF80010
`define CFG_WORD_STEP 24'h000002
`define CFG_WORD4_GAP 24'h000002
`define CFG_LAST_PM_WORD 24'h00ABFE
// ---------------------------------------------------------------
// Field positions inside the 8-bit registers
// ---------------------------------------------------------------
`define FLD_BSS_LSB 1
`define FLD_PPF_LSB 0
`define FLD_SEND_BIT 0
`define FLD_LPP_BIT 1
`define FLD_SPD_BIT 2
`define FLD_NOSC_LSB 0
`define FLD_CKSM_LSB 6
`define FLD_POSC_LSB 0
`define FLD_LOCK_BIT 5
`define FLD_WDPS_LSB 0
`define CFG_REG_RESET 8'hFF
`define CFG_NUM_WORDS 4
`endif

// >>> inc/cfgload_pkg.sv
// Types of the configuration word loader.
// Assumes the constants header is compiled alongside.
`default_nettype none
package cfgload_pkg;
  typedef enum logic [2:0] {ST_RESET, ST_REQ, ST_WAIT, ST_NEXT, ST_RUN} load_state_e;
  typedef logic [7:0] cfg_byte_t;
  typedef logic [15:0] cfg_word_t;
  typedef logic [23:0] cfg_addr_t;
endpackage
`default_nettype wire

// >>> inc/cfg_field_if.sv
// Carrier of one write-once configuration register's write and state.
// Assumes one clock domain shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface cfg_field_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] value;
  logic mismatch;
  modport ctl (output wr_en, output wr_data, input value, input mismatch);
  modport reg_end (input wr_en, input wr_data, output value, output mismatch);
endinterface
`default_nettype wire

// >>> design/cfg_once_reg.sv
// One 8-bit configuration register with write-once or nonvolatile mode.
// Assumes load writes come first after reset in the volatile mode.
`timescale 1ns/10ps
`default_nettype none
`include "cfgload_cfg.svh"
module cfg_once_reg (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic nonvolatile,
  input wire logic clear_lock,
  // Register side
  cfg_field_if.reg_end fi
);
  logic [7:0] value_r;
  logic written_r;
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_r <= `CFG_REG_RESET; // RQ7
    end else if (ce && fi.wr_en && (nonvolatile || !written_r)) begin
      value_r <= fi.wr_data; // RQ15
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      written_r <= 1'b0;
    end else if (ce) begin
      if (clear_lock) begin
        written_r <= 1'b0;
      end else if (fi.wr_en) begin
        written_r <= 1'b1; // RQ8
      end
    end
  end
  // Blocked change attempt on a locked volatile bit
  assign fi.value = value_r;
  assign fi.mismatch = !nonvolatile && written_r && fi.wr_en && (fi.wr_data != value_r); // RQ9
endmodule
`default_nettype wire

// >>> design/cfg_word_scatter.sv
// Scatters one packed flash word into two configuration bytes.
// Assumes caller picks the target byte indexes per word.
`timescale 1ns/10ps
`default_nettype none
module cfg_word_scatter (
  // Packed image
  input wire logic [15:0] word,
  // Scattered bytes
  output logic [7:0] lo_byte,
  output logic [7:0] hi_byte
);
  // Upper byte of the 24-bit flash word is never read here
  assign lo_byte = word[7:0]; // RQ4 RQ11
  assign hi_byte = word[15:8];
endmodule
`default_nettype wire

// >>> tb/flash_cfg_model.sv
// Behavioural flash holding the packed configuration words.
// Assumes one read outstanding; lag sets extra wait cycles per answer.
`timescale 1ns/10ps
`default_nettype none
module flash_cfg_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Read port
  input wire logic rd,
  input wire logic [23:0] addr,
  input wire logic [3:0] lag,
  output logic valid,
  output logic [23:0] data
);
  logic [15:0] mem [4];
  logic [23:0] k;
  int i;
  // ---------------------------------------------------------------
  // Answer each read after lag cycles
  // ---------------------------------------------------------------
  initial begin
    valid = 1'b0;
    data = 24'h000000;
    forever begin
      @(posedge clk);
      if (rd === 1'b1 && rst === 1'b0) begin
        k = (24'h00ABFE - addr) >> 1;
        for (i = 0; i < lag; i++) begin
          data <= ~data;
          @(posedge clk);
        end
        valid <= 1'b1;
        // Upper byte kept all ones so the word reads as a no-op
        data <= (k < 24'h000004) ? {8'hFF, mem[k[1:0]]} : 24'hA5A5A5;
        @(posedge clk);
        valid <= 1'b0;
        // Released data never keeps the last value
        data <= ~data;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_config_word_loader.sv
// Self-checking bench of the configuration word loader.
// Assumes the flash model answers by address; fixed seed for repeatability.
`timescale 1ns/10ps
`default_nettype none
module tb_config_word_loader;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic NONVOLATILE = 1'b0;
  logic [2:0] NUM_WORDS = 3'h4;
  logic SOFT_RESET = 1'b0;
  logic NV_DISRUPT = 1'b0;
  logic CE = 1'b1;
  logic TBL_WR = 1'b0;
  logic TBL_RD = 1'b0;
  logic [23:0] TBL_ADDR = 24'h000000;
  logic [7:0] TBL_WDATA = 8'h00;
  logic [3:0] lag = 4'h0;
  logic frd, fvalid, rvalid, core_rst, mm_rst, lock, send, spe, lpp, mm;
  logic [23:0] faddr, fdata, rdata;
  logic [2:0] boot_segment_security, nosc;
  logic [1:0] cksm, posc;
  logic [3:0] wdps;
  logic [7:0] ppf;
  logic [15:0] words [4];
  logic [7:0] er [8];
  int seed = 66934;
  int err_total = 0;
  int checked = 0;
  always #2 CLK = ~CLK;
  flash_cfg_model u_flash_cfg_model (.clk(CLK), .rst(RST), .rd(frd), .addr(faddr), .lag(lag),
    .valid(fvalid), .data(fdata));
  config_word_loader u_config_word_loader (.CLK(CLK), .RST(RST), .CE(CE),
    .NONVOLATILE(NONVOLATILE), .NUM_WORDS(NUM_WORDS), .SOFT_RESET(SOFT_RESET),
    .NV_DISRUPT(NV_DISRUPT), .FLASH_RD(frd), .FLASH_ADDR(faddr), .FLASH_VALID(fvalid),
    .FLASH_DATA(fdata), .TBL_WR(TBL_WR), .TBL_RD(TBL_RD), .TBL_ADDR(TBL_ADDR),
    .TBL_WDATA(TBL_WDATA), .TBL_RDATA(rdata), .TBL_RVALID(rvalid), .CORE_RESET(core_rst),
    .CONFIG_MISMATCH_RESET(mm_rst), .BOOT_SEGMENT_SECURITY(boot_segment_security),
    .CLOCK_SWITCH_MONITOR_SEL(cksm), .INITIAL_OSCILLATOR_SEL(nosc),
    .PRIMARY_OSCILLATOR_MODE(posc), .WATCHDOG_POSTSCALER(wdps), .PIN_MAPPING_LOCK(lock),
    .PROTECT_PAGE_FIELD(ppf), .SEGMENT_END_SELECT(send), .SEGMENT_PROTECT_ENABLE(spe),
    .LAST_PAGE_PROTECT(lpp));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] addr_of(input int i);
    return (i == 0) ? 24'hF80000 : 24'hF80002 + 24'(2 * i);
  endfunction
  // Random words, expected bytes scattered low then high
  task automatic fill(input int n);
    for (int k = 0; k < 4; k++) begin
      words[k] = 16'($random(seed));
      u_flash_cfg_model.mem[k] = words[k];
    end
    for (int i = 0; i < 8; i++)
      er[i] = (i / 2 < n) ? ((i % 2) ? words[i / 2][15:8] : words[i / 2][7:0]) : 8'hFF;
  endtask
  task automatic tbl_wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge CLK);
    TBL_WR <= 1'b1;
    TBL_ADDR <= a;
    TBL_WDATA <= d;
    @(posedge CLK);
    TBL_WR <= 1'b0;
  endtask
  task automatic tbl_rd(input logic [23:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge CLK);
    TBL_RD <= 1'b1;
    TBL_ADDR <= a;
    @(posedge CLK);
    TBL_RD <= 1'b0;
    #1;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk(rvalid, 1'b1);
    chk(rdata, {16'h0000, exp});
  endtask
  task automatic wait_mm(output logic seen);
    // The pulse stands one cycle from the edge that takes the request
    seen = 1'b0;
    #1;
    repeat (4) begin
      if (mm_rst === 1'b1)
        seen = 1'b1;
      @(posedge CLK);
      #1;
    end
  endtask
  // Core must stay in reset until the last word lands
  task automatic wait_load();
    int n;
    n = 0;
    @(posedge CLK);
    #1;
    if (!NONVOLATILE)
      chk(core_rst, 1'b1);
    while (core_rst !== 1'b0 && n < 200) begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk(core_rst, 1'b0);
  endtask
  task automatic do_reset();
    @(posedge CLK);
    RST <= 1'b1;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    wait_load();
  endtask
  task automatic check_regs();
    for (int i = 0; i < 8; i++)
      tbl_rd(addr_of(i), er[i]);
  endtask
  task automatic check_opts();
    chk(boot_segment_security, er[0][3:1]);
    chk(ppf, er[1]);
    chk(nosc, er[2][2:0]);
    chk({cksm, lock, posc}, {er[3][7:5], er[3][1:0]});
    chk(wdps, er[4][3:0]);
    chk({send, lpp, spe}, {er[6][0], ~er[6][1], ~er[6][2]});
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    fill(4);
    do_reset();
    check_regs();
    check_opts();
    // Soft reset while frozen must not start a reload
    @(posedge CLK);
    CE <= 1'b0;
    SOFT_RESET <= 1'b1;
    repeat (3) @(posedge CLK);
    SOFT_RESET <= 1'b0;
    @(posedge CLK);
    CE <= 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    chk(core_rst, 1'b0);
    tbl_rd(24'hF80002, 8'h00);
    // Equal rewrite of a locked byte is blocked quietly
    tbl_wr(addr_of(3), er[3]);
    wait_mm(mm);
    chk(mm, 1'b0);
    // Differing rewrite reloads the original values
    tbl_wr(addr_of(1), ~er[1]);
    wait_mm(mm);
    chk(mm, 1'b1);
    wait_load();
    check_regs();
    // New flash contents take hold only at the software reset
    fill(4);
    wait_mm(mm);
    chk(mm, 1'b0);
    @(posedge CLK);
    SOFT_RESET <= 1'b1;
    @(posedge CLK);
    SOFT_RESET <= 1'b0;
    wait_load();
    check_regs();
    check_opts();
    // Two words from a slow flash leave the rest unprogrammed
    lag <= 4'h5;
    NUM_WORDS <= 3'h2;
    fill(2);
    do_reset();
    check_regs();
    // Nonvolatile writes act at once, one write to each of registers 0 to 5
    NONVOLATILE <= 1'b1;
    fill(0);
    do_reset();
    for (int j = 0; j < 6; j++) begin
      er[j % 8] = 8'($random(seed));
      tbl_wr(addr_of(j % 8), er[j % 8]);
      tbl_rd(addr_of(j % 8), er[j % 8]);
    end
    check_opts();
    wait_mm(mm);
    chk(mm, 1'b0);
    @(posedge CLK);
    NV_DISRUPT <= 1'b1;
    @(posedge CLK);
    NV_DISRUPT <= 1'b0;
    wait_mm(mm);
    chk(mm, 1'b1);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
